// >>> src/lst_pkg.sv
// package: opcodes, field values, clock counts and data cycle counts
// assumes: a decoder that sees one instruction byte per clock
package lst_pkg;
	// ***************************************************
	// opcode patterns (width bit stripped where present)
	// ***************************************************
	localparam logic [6:0] OP_AND_RM = 7'h10;
	localparam logic [6:0] OP_AND_MR = 7'h11;
	localparam logic [6:0] OP_AND_ACC = 7'h12;
	localparam logic [5:0] OP_AND_RR = 6'h08;
	localparam logic [5:0] OP_IMM_GRP = 6'h20;
	localparam logic [6:0] OP_TEST_RM = 7'h42;
	localparam logic [6:0] OP_UNARY_GRP = 7'h7B;
	localparam logic [6:0] OP_TEST_ACC = 7'h54;
	localparam logic [5:0] OP_OR_RR = 6'h02;
	localparam logic [6:0] OP_OR_ACC = 7'h06;
	localparam logic [5:0] OP_XOR_RR = 6'h0C;
	localparam logic [6:0] OP_XOR_ACC = 7'h1A;
	localparam logic [6:0] OP_COMPARE_STRING_OP = 7'h53;
	localparam logic [6:0] OP_INS = 7'h36;
	localparam logic [6:0] OP_LOAD_STRING_OP = 7'h56;
	localparam logic [6:0] OP_MOVE_STRING_OP = 7'h52;
	localparam logic [6:0] OP_PORT_OUTPUT_STRING_OP = 7'h37;
	localparam logic [6:0] OP_SCAN_STRING_OP = 7'h57;
	localparam logic [6:0] OP_STORE_STRING_OP = 7'h55;
	localparam logic [7:0] OP_TABLE_TRANSLATE_OP = 8'hD7;
	localparam logic [7:0] PFX_REPEAT_WHILE_EQUAL_PREFIX = 8'hF3;
	// ***************************************************
	// reg field selectors and mod value for a register
	// ***************************************************
	localparam logic [2:0] SEL_AND = 3'h4;
	localparam logic [2:0] SEL_OR = 3'h1;
	localparam logic [2:0] SEL_XOR = 3'h6;
	localparam logic [2:0] SEL_TEST = 3'h0;
	localparam logic [2:0] SEL_NOT = 3'h2;
	localparam logic [1:0] MOD_REG = 2'h3;
	// ***************************************************
	// clock counts and repeat data cycles
	// ***************************************************
	localparam logic [5:0] CLK_REG = 6'h02;
	localparam logic [5:0] CLK_LOGIC_MR = 6'h06;
	localparam logic [5:0] CLK_LOGIC_RM = 6'h07;
	localparam logic [5:0] CLK_TEST_MEM = 6'h05;
	localparam logic [5:0] CLK_NOT_MEM = 6'h06;
	localparam logic [5:0] CLK_COMPARE_STRING_OP = 6'h0A;
	localparam logic [5:0] CLK_INS_A = 6'h09;
	localparam logic [5:0] CLK_INS_B = 6'h1D;
	localparam logic [5:0] CLK_LOAD_STRING_OP = 6'h05;
	localparam logic [5:0] CLK_MOVE_STRING_OP = 6'h07;
	localparam logic [5:0] CLK_PORT_OUTPUT_STRING_OP_A = 6'h08;
	localparam logic [5:0] CLK_PORT_OUTPUT_STRING_OP_B = 6'h1C;
	localparam logic [5:0] CLK_SCAN_STRING_OP = 6'h07;
	localparam logic [5:0] CLK_STORE_STRING_OP = 6'h04;
	localparam logic [5:0] CLK_TABLE_TRANSLATE_OP = 6'h05;
	localparam logic [5:0] CLK_REP_BASE = 6'h05;
	localparam logic [5:0] CLK_REP_ITER = 6'h09;
	localparam logic [1:0] DC_REP_ITER = 2'h2;
	// ***************************************************
	// operation classes
	// ***************************************************
	typedef enum logic [3:0] {
		LST_NONE = 4'h0, LST_AND = 4'h1, LST_OR = 4'h2, LST_XOR = 4'h3,
		LST_TEST = 4'h4, LST_NOT = 4'h5, LST_COMPARE_STRING_OP = 4'h6, LST_INS = 4'h7,
		LST_LOAD_STRING_OP = 4'h8, LST_MOVE_STRING_OP = 4'h9, LST_PORT_OUTPUT_STRING_OP = 4'hA, LST_SCAN_STRING_OP = 4'hB,
		LST_STORE_STRING_OP = 4'hC, LST_TABLE_TRANSLATE_OP = 4'hD
	} lst_op_e;
endpackage : lst_pkg

// >>> src/lst_decode.sv
// decoder: maps opcode and mode byte to class, clocks and data cycles
// assumes: opcode and mode byte are already held stable by the caller
`timescale 1ns/100ps
`default_nettype none
module lst_decode
	import lst_pkg::*;
(
	// instruction bytes
	input wire logic [7:0] opcode,
	input wire logic [7:0] modrm,
	input wire logic slow_io,
	// decode result
	output lst_pkg::lst_op_e op,
	output logic [5:0] clocks,
	output logic [1:0] data_cycles,
	output logic needs_modrm,
	output logic result_kept,
	output logic valid
);
	logic is_reg;
	logic [2:0] sel;
	assign is_reg = (modrm[7:6] == MOD_REG); // RULE21
	assign sel = modrm[5:3];
	always_comb
	begin
		op = LST_NONE;
		clocks = CLK_REG;
		data_cycles = 2'h0;
		needs_modrm = 1'b0;
		result_kept = 1'b1;
		valid = 1'b1;
		if (opcode[7:2] == OP_AND_RR || opcode[7:2] == OP_OR_RR ||
			opcode[7:2] == OP_XOR_RR)
		begin
			// d bit: 1 means reg field is the destination
			op = (opcode[7:2] == OP_AND_RR) ? LST_AND :
				(opcode[7:2] == OP_OR_RR) ? LST_OR : LST_XOR; // RULE20
			needs_modrm = 1'b1;
			if (is_reg)
				clocks = CLK_REG; // RULE6 RULE7
			else if (opcode[1])
			begin
				clocks = CLK_LOGIC_MR; // RULE1
				data_cycles = 2'h1;
			end
			else
			begin
				clocks = CLK_LOGIC_RM; // RULE1
				data_cycles = 2'h2;
			end
		end
		else if (opcode[7:1] == OP_AND_ACC || opcode[7:1] == OP_OR_ACC ||
			opcode[7:1] == OP_XOR_ACC)
		begin
			op = (opcode[7:1] == OP_AND_ACC) ? LST_AND :
				(opcode[7:1] == OP_OR_ACC) ? LST_OR : LST_XOR; // RULE2 RULE6 RULE8
			clocks = CLK_REG;
		end
		else if (opcode[7:2] == OP_IMM_GRP && opcode[1] == 1'b0)
		begin
			needs_modrm = 1'b1;
			clocks = is_reg ? CLK_REG : CLK_LOGIC_RM; // RULE2 RULE5 RULE8
			data_cycles = is_reg ? 2'h0 : 2'h2;
			if (sel == SEL_AND)
				op = LST_AND;
			else if (sel == SEL_OR)
				op = LST_OR;
			else if (sel == SEL_XOR)
				op = LST_XOR;
			else
				valid = 1'b0;
		end
		else if (opcode[7:1] == OP_TEST_RM || opcode[7:1] == OP_TEST_ACC)
		begin
			op = LST_TEST;
			result_kept = 1'b0; // RULE3
			needs_modrm = (opcode[7:1] == OP_TEST_RM);
			if (needs_modrm && !is_reg)
			begin
				clocks = CLK_TEST_MEM; // RULE3
				data_cycles = 2'h1;
			end
		end
		else if (opcode[7:1] == OP_UNARY_GRP)
		begin
			needs_modrm = 1'b1;
			if (sel == SEL_TEST)
			begin
				op = LST_TEST;
				result_kept = 1'b0;
				clocks = is_reg ? CLK_REG : CLK_TEST_MEM; // RULE4
				data_cycles = is_reg ? 2'h0 : 2'h1;
			end
			else if (sel == SEL_NOT)
			begin
				op = LST_NOT;
				clocks = is_reg ? CLK_REG : CLK_NOT_MEM; // RULE9
				data_cycles = is_reg ? 2'h0 : 2'h2;
			end
			else
				valid = 1'b0;
		end
		else if (opcode == OP_TABLE_TRANSLATE_OP)
		begin
			op = LST_TABLE_TRANSLATE_OP;
			clocks = CLK_TABLE_TRANSLATE_OP; // RULE17
			data_cycles = 2'h1;
		end
		else
		begin
			data_cycles = 2'h1;
			unique case (opcode[7:1])
				OP_COMPARE_STRING_OP:
				begin
					op = LST_COMPARE_STRING_OP;
					clocks = CLK_COMPARE_STRING_OP; // RULE10
					data_cycles = 2'h2;
				end
				OP_INS:
				begin
					op = LST_INS;
					clocks = slow_io ? CLK_INS_B : CLK_INS_A; // RULE11
				end
				OP_LOAD_STRING_OP:
				begin
					op = LST_LOAD_STRING_OP;
					clocks = CLK_LOAD_STRING_OP; // RULE12
				end
				OP_MOVE_STRING_OP:
				begin
					op = LST_MOVE_STRING_OP;
					clocks = CLK_MOVE_STRING_OP; // RULE13
					data_cycles = 2'h2;
				end
				OP_PORT_OUTPUT_STRING_OP:
				begin
					op = LST_PORT_OUTPUT_STRING_OP;
					clocks = slow_io ? CLK_PORT_OUTPUT_STRING_OP_B : CLK_PORT_OUTPUT_STRING_OP_A; // RULE14
				end
				OP_SCAN_STRING_OP:
				begin
					op = LST_SCAN_STRING_OP;
					clocks = CLK_SCAN_STRING_OP; // RULE15
				end
				OP_STORE_STRING_OP:
				begin
					op = LST_STORE_STRING_OP;
					clocks = CLK_STORE_STRING_OP; // RULE16
				end
				default:
				begin
					valid = 1'b0;
					data_cycles = 2'h0;
				end
			endcase
		end
	end
endmodule : lst_decode
`default_nettype wire

// >>> src/lst_core.sv
// top: takes instruction bytes, times execution, issues data cycles
// assumes: bytes come from fetch logic on clk; bus answers with bus_done
// What this block does
// [RULE1] AND memory forms: 6 clocks/1, 7 clocks/2
// [RULE2] AND immediate reg field 100, 2/7 clocks
// [RULE3] test ANDs, sets flags, drops result
// [RULE4] test immediate reg field 000, 2/5 clocks
// [RULE5] OR immediate reg field 001, 2/7 clocks
// [RULE6] OR accumulator and register forms take 2
// [RULE7] XOR register 2, memory 7 or 6
// [RULE8] XOR immediate reg field 110, 2/7 clocks
// [RULE9] invert reg field 010, 2/6 clocks
// [RULE10] compare string: 10 clocks, two cycles
// [RULE11] port input string: 9 or 29 clocks
// [RULE12] load string: 5 clocks, one cycle
// [RULE13] move string: 7 clocks, read then write
// [RULE14] port output string: 8 or 28 clocks
// [RULE15] scan string: 7 clocks, one cycle
// [RULE16] store string: 4 clocks, one cycle
// [RULE17] table translate byte: 5 clocks, one cycle
// [RULE18] repeats count from 16 or 32-bit count
// [RULE19] repeat-equal compare: 5+9n, stop on mismatch
// [RULE20] width bit picks byte; direction picks destination
// [RULE21] slash counts: register first, memory second
`timescale 1ns/100ps
`default_nettype none
module lst_core
	import lst_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// instruction byte stream
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	// machine state
	input wire logic addr32,
	input wire logic slow_io,
	input wire logic [31:0] count_in,
	input wire logic compare_equal,
	// data bus
	output logic bus_req,
	output logic bus_write,
	output logic bus_io,
	output logic bus_width_full,
	input wire logic bus_done,
	// status
	output lst_pkg::lst_op_e op_out,
	output logic flags_only,
	output logic writes_accumulator,
	output logic busy,
	output logic done,
	output logic illegal
);
	import lst_pkg::*;
	// ***************************************************
	// state and storage
	// ***************************************************
	typedef enum logic [4:0] {
		ST_OPC = 5'b00001, ST_MODRM = 5'b00010, ST_EXEC = 5'b00100,
		ST_REP = 5'b01000, ST_DONE = 5'b10000
	} lst_state_e;
	lst_state_e state_reg;
	logic [7:0] opcode_reg;
	logic [7:0] modrm_reg;
	logic rep_reg;
	logic opc_seen_reg;
	logic [31:0] count_reg;
	logic [5:0] cyc_reg;
	logic [1:0] dc_reg;
	logic bus_req_reg;
	logic flags_reg;
	logic wacc_reg;
	logic width_reg;
	logic illegal_reg;
	lst_op_e op_reg;
	lst_op_e dec_op;
	logic [5:0] dec_clocks;
	logic [1:0] dec_dc;
	logic dec_modrm;
	logic dec_kept;
	logic dec_valid;
	logic [7:0] modrm_view;
	logic exec_end;
	logic [31:0] count_start;
	// the mode byte is not yet held while the opcode is in the first state;
	// while it is offered, decode from the pin so the count matches its mode
	assign modrm_view = (state_reg == ST_OPC) ? 8'hC0 :
		(state_reg == ST_MODRM) ? byte_data : modrm_reg;
	lst_decode u_dec (
		.opcode(opcode_reg),
		.modrm(modrm_view),
		.slow_io(slow_io),
		.op(dec_op),
		.clocks(dec_clocks),
		.data_cycles(dec_dc),
		.needs_modrm(dec_modrm),
		.result_kept(dec_kept),
		.valid(dec_valid)
	);
	// ***************************************************
	// handshakes
	// ***************************************************
	// no fetch in the decode cycle, or the mode byte lands as an opcode
	assign byte_ready = ((state_reg == ST_OPC) && !opc_seen_reg) ||
		(state_reg == ST_MODRM);
	assign count_start = addr32 ? count_in : {16'h0000, count_in[15:0]}; // RULE18
	// the last clock of an execution; bus still owes a cycle holds it off
	assign exec_end = (cyc_reg == 6'h01) && (dc_reg == 2'h0) && !bus_req_reg;
	// ***************************************************
	// sequencing
	// ***************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_OPC;
			opcode_reg <= 8'h00;
			modrm_reg <= 8'h00;
			rep_reg <= 1'b0;
			count_reg <= 32'h0;
			opc_seen_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				ST_OPC:
				begin
					if (opc_seen_reg)
					begin
						opc_seen_reg <= 1'b0;
						state_reg <= dec_modrm ? ST_MODRM : ST_EXEC;
						count_reg <= count_start; // RULE18
					end
					else if (byte_valid && byte_data == PFX_REPEAT_WHILE_EQUAL_PREFIX)
						rep_reg <= 1'b1; // RULE19
					else if (byte_valid)
					begin
						opcode_reg <= byte_data;
						opc_seen_reg <= 1'b1;
					end
				end
				ST_MODRM:
				begin
					if (byte_valid)
					begin
						modrm_reg <= byte_data;
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC:
				begin
					if (!dec_valid)
						state_reg <= ST_DONE;
					else if (exec_end && rep_reg)
					begin
						count_reg <= count_reg - 32'h1;
						if (count_reg == 32'h1 || !compare_equal) // RULE19
							state_reg <= ST_DONE;
						else
							state_reg <= ST_REP;
					end
					else if (exec_end)
						state_reg <= ST_DONE;
				end
				ST_REP:
					state_reg <= ST_EXEC;
				ST_DONE:
				begin
					state_reg <= ST_OPC;
					rep_reg <= 1'b0;
					modrm_reg <= 8'h00;
				end
				default:
					state_reg <= ST_OPC;
			endcase
		end
	end
	// ***************************************************
	// clock counting and data cycles
	// ***************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cyc_reg <= 6'h00;
			dc_reg <= 2'h0;
			bus_req_reg <= 1'b0;
		end
		else if (state_reg == ST_MODRM || (state_reg == ST_OPC && opc_seen_reg
			&& !dec_modrm))
		begin
			// repeated forms open with the setup clocks, then one pass
			cyc_reg <= rep_reg ? 6'(CLK_REP_BASE + CLK_REP_ITER) :
				dec_clocks; // RULE19
			dc_reg <= rep_reg ? DC_REP_ITER : dec_dc;
		end
		else if (state_reg == ST_REP)
		begin
			cyc_reg <= CLK_REP_ITER; // RULE19
			dc_reg <= DC_REP_ITER;
		end
		else if (state_reg == ST_EXEC)
		begin
			if (cyc_reg > 6'h01)
				cyc_reg <= cyc_reg - 6'h01;
			if (bus_req_reg && bus_done)
				bus_req_reg <= 1'b0;
			else if (!bus_req_reg && dc_reg != 2'h0 && dec_valid)
			begin
				bus_req_reg <= 1'b1;
				dc_reg <= dc_reg - 2'h1;
			end
		end
	end
	// ***************************************************
	// result attributes
	// ***************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_reg <= LST_NONE;
			flags_reg <= 1'b0;
			wacc_reg <= 1'b0;
			width_reg <= 1'b0;
			illegal_reg <= 1'b0;
		end
		else if (state_reg == ST_EXEC)
		begin
			op_reg <= dec_op;
			flags_reg <= !dec_kept; // RULE3
			wacc_reg <= (dec_op == LST_LOAD_STRING_OP) || (dec_op == LST_TABLE_TRANSLATE_OP); // RULE12
			width_reg <= (opcode_reg == OP_TABLE_TRANSLATE_OP) ? 1'b0 : opcode_reg[0]; // RULE20
			illegal_reg <= !dec_valid;
		end
	end
	// second of two data cycles writes for read-modify-write and move
	always_comb
	begin
		bus_write = 1'b0;
		if (bus_req_reg)
		begin
			unique case (op_reg)
				LST_STORE_STRING_OP, LST_PORT_OUTPUT_STRING_OP:
					bus_write = 1'b1; // RULE14 RULE16
				LST_MOVE_STRING_OP, LST_AND, LST_OR, LST_XOR, LST_NOT:
					bus_write = (dc_reg == 2'h0) && dec_kept && // RULE13
						(dec_dc == 2'h2); // RULE1
				default:
					bus_write = 1'b0;
			endcase
		end
	end
	assign bus_req = bus_req_reg;
	assign bus_io = bus_req_reg && (op_reg == LST_INS || op_reg == LST_PORT_OUTPUT_STRING_OP); // RULE11
	assign bus_width_full = width_reg;
	assign op_out = op_reg;
	assign flags_only = flags_reg;
	assign writes_accumulator = wacc_reg;
	assign busy = (state_reg != ST_OPC);
	assign done = (state_reg == ST_DONE);
	assign illegal = illegal_reg && (state_reg == ST_DONE);
	// ***************************************************
	// checks
	// ***************************************************
	property p_test_no_result;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_EXEC && dec_op == LST_TEST) |=> flags_only;
	endproperty
	a_test_no_result: assert property (p_test_no_result) // RULE3
		else $error("test op kept its result");
	sequence s_rep_start;
		state_reg == ST_REP;
	endsequence
	property p_rep_reload;
		@(posedge clk) disable iff (rst)
		s_rep_start |=> (cyc_reg == CLK_REP_ITER && dc_reg == DC_REP_ITER);
	endproperty
	a_rep_reload: assert property (p_rep_reload) // RULE19
		else $error("repeat pass not reloaded");
	property p_done_one;
		@(posedge clk) disable iff (rst)
		done |=> !done;
	endproperty
	a_done_one: assert property (p_done_one) // RULE21
		else $error("done held too long");
	// a data cycle, once asked for, stays up until the bus answers it
	sequence s_bus_waiting;
		bus_req && !bus_done;
	endsequence
	property p_bus_hold;
		@(posedge clk) disable iff (rst)
		s_bus_waiting |=> bus_req;
	endproperty
	a_bus_hold: assert property (p_bus_hold) // RULE13
		else $error("data cycle dropped before its answer");
	// a one-cycle memory form only reads; stores and port output excepted
	property p_single_read;
		@(posedge clk) disable iff (rst)
		(bus_req && dec_dc == 2'h1 && op_reg != LST_STORE_STRING_OP &&
			op_reg != LST_PORT_OUTPUT_STRING_OP) |-> !bus_write;
	endproperty
	a_single_read: assert property (p_single_read) // RULE1
		else $error("one-cycle memory form wrote");
	// the decode cycle must not let the next byte replace the opcode
	property p_opcode_kept;
		@(posedge clk) disable iff (rst)
		(state_reg == ST_OPC && opc_seen_reg) |=> $stable(opcode_reg);
	endproperty
	a_opcode_kept: assert property (p_opcode_kept) // RULE1
		else $error("opcode replaced during decode");
	// register forms without a repeat prefix load the register count whatever their group
	sequence s_reg_mode_taken;
		state_reg == ST_MODRM && byte_valid && byte_data[7:6] == MOD_REG;
	endsequence
	property p_reg_form;
		@(posedge clk) disable iff (rst)
		(s_reg_mode_taken ##0 !rep_reg) |=>
			(cyc_reg == CLK_REG && dc_reg == 2'h0);
	endproperty
	a_reg_form: assert property (p_reg_form) // RULE21
		else $error("register form given a memory count");
	// a repeat pass ends; what follows depends on the count and compare
	sequence s_rep_pass_end;
		state_reg == ST_EXEC && dec_valid && exec_end && rep_reg;
	endsequence
	property p_rep_mismatch;
		@(posedge clk) disable iff (rst)
		(s_rep_pass_end ##0 !compare_equal) |=> done;
	endproperty
	a_rep_mismatch: assert property (p_rep_mismatch) // RULE19
		else $error("repeat went on past a mismatch");
	property p_rep_last;
		@(posedge clk) disable iff (rst)
		(s_rep_pass_end ##0 (count_reg == 32'h1)) |=> done;
	endproperty
	a_rep_last: assert property (p_rep_last) // RULE18
		else $error("repeat went on past its count");
	property p_rep_more;
		@(posedge clk) disable iff (rst)
		(s_rep_pass_end ##0 (compare_equal && count_reg != 32'h1)) |=>
			(state_reg == ST_REP);
	endproperty
	a_rep_more: assert property (p_rep_more) // RULE18
		else $error("repeat stopped early");
endmodule : lst_core
`default_nettype wire

// >>> verification/lst_bus_model.sv
// bus model: answers each data cycle after a random wait
// assumes: request held until answered, answer sampled on rising edge
`timescale 1ns/100ps
`default_nettype none
module lst_bus_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// data bus
	input wire logic bus_req,
	input wire logic bus_write,
	input wire logic bus_io,
	input wire logic bus_width_full,
	output logic bus_done
);
	int wait_cnt;
	int waits;
	logic [2:0] log_q[$];
	// ****************************
	// answer logic
	// ****************************
	// done is one pulse; the wait is drawn anew so slow and prompt both occur
	always @(negedge clk or posedge rst)
	begin
		if (rst)
		begin
			bus_done <= 1'b0;
			wait_cnt <= 0;
		end
		else if (bus_done)
		begin
			bus_done <= 1'b0;
			wait_cnt <= $urandom_range(2, 0);
		end
		else if (bus_req && wait_cnt == 0)
		begin
			bus_done <= 1'b1;
			log_q.push_back({bus_write, bus_io, bus_width_full});
		end
		else if (bus_req)
		begin
			wait_cnt <= wait_cnt - 1;
			waits++;
		end
	end
endmodule : lst_bus_model
`default_nettype wire

// >>> verification/logic_string_instr_timing_test.sv
// testbench: feeds instruction bytes, compares with a behavioural model
// assumes: lst_core fetches bytes on handshake and ends with done
`timescale 1ns/100ps
`default_nettype none
module logic_string_instr_timing_test;
	import lst_pkg::*;
	logic clk, rst, byte_valid, addr32, slow_io, compare_equal;
	logic [7:0] byte_data;
	logic [31:0] count_in;
	logic byte_ready, bus_req, bus_write, bus_io, bus_width_full, bus_done;
	logic flags_only, writes_accumulator, busy, done, illegal;
	lst_op_e op_out;
	int err_total, n_compared, cyc;
	// ****************************
	// case table: opcode, mode byte
	// ****************************
	logic [15:0] tbl [35] = '{
		16'h2000, 16'h2200, 16'h20C0,
		16'h8020, 16'h80E0, 16'h2400,
		16'h8400, 16'h84C0,
		16'hF600, 16'hF6C0, 16'hA800,
		16'h8008, 16'h80C8,
		16'h0C00, 16'h08C0, 16'h0800, 16'h0A00,
		16'h3000, 16'h3200, 16'h30C0,
		16'h8030, 16'h80F0, 16'h3400,
		16'hF610, 16'hF6D0,
		16'hA600, 16'h6C00, 16'hAC00, 16'hA400,
		16'h6E00, 16'hAE00, 16'hAA00, 16'hD700,
		16'hF618, 16'h9000};
	lst_core lst_core_inst (.clk(clk), .rst(rst), .byte_valid(byte_valid),
		.byte_data(byte_data), .byte_ready(byte_ready), .addr32(addr32),
		.slow_io(slow_io), .count_in(count_in),
		.compare_equal(compare_equal), .bus_req(bus_req),
		.bus_write(bus_write), .bus_io(bus_io),
		.bus_width_full(bus_width_full), .bus_done(bus_done),
		.op_out(op_out), .flags_only(flags_only),
		.writes_accumulator(writes_accumulator), .busy(busy), .done(done),
		.illegal(illegal));
	lst_bus_model lst_bus_model_inst (.clk(clk), .rst(rst),
		.bus_req(bus_req), .bus_write(bus_write), .bus_io(bus_io),
		.bus_width_full(bus_width_full), .bus_done(bus_done));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// cycle count doubles as the hang limit
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	task automatic send(input logic [7:0] b);
		int k;
		k = 0;
		@(negedge clk);
		byte_valid = 1'b1;
		byte_data = b;
		while (byte_ready !== 1'b1 && k < 100)
		begin
			@(negedge clk);
			k++;
		end
		chk("byte ready", 1, byte_ready);
		@(posedge clk);
	endtask : send
	// expected class, clocks, data cycles, write mask, io, flags, refusal
	function automatic void model(input logic [7:0] o, m, input bit slow,
		output lst_op_e c, output int ck, dc, wr, io, fl, il, hm);
		logic mem;
		logic [2:0] r;
		mem = m[7:6] != 2'b11;
		r = m[5:3];
		c = LST_NONE;
		ck = 2;
		{dc, wr, io, fl, il, hm} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0, 32'd1};
		case (o[7:1])
			7'h10, 7'h11, 7'h04, 7'h05, 7'h18, 7'h19:
			begin
				c = o[4] ? LST_XOR : (o[3] ? LST_OR : LST_AND);
				if (mem && !o[1])
					{ck, dc, wr} = {32'd7, 32'd2, 32'd2};
				else if (mem)
					{ck, dc} = {32'd6, 32'd1};
			end
			7'h12, 7'h06, 7'h1A:
			begin
				c = o[4] ? LST_XOR : (o[3] ? LST_OR : LST_AND);
				hm = 0;
			end
			7'h40, 7'h41:
			begin
				c = r == 4 ? LST_AND : r == 1 ? LST_OR : r == 6 ? LST_XOR : LST_NONE;
				il = c == LST_NONE;
				if (mem)
					{ck, dc, wr} = {32'd7, 32'd2, 32'd2};
			end
			7'h42:
			begin
				c = LST_TEST;
				fl = 1;
				if (mem)
					{ck, dc} = {32'd5, 32'd1};
			end
			7'h7B:
			begin
				c = r == 0 ? LST_TEST : r == 2 ? LST_NOT : LST_NONE;
				il = c == LST_NONE;
				fl = r == 0;
				if (mem)
					{ck, dc, wr} = r == 0 ? {32'd5, 32'd1, 32'd0} : {32'd6, 32'd2, 32'd2};
			end
			7'h54:
			begin
				c = LST_TEST;
				{fl, hm} = {32'd1, 32'd0};
			end
			7'h53:
			begin
				c = LST_COMPARE_STRING_OP;
				{ck, dc, hm} = {32'd10, 32'd2, 32'd0};
			end
			7'h36:
			begin
				c = LST_INS;
				ck = slow ? 29 : 9;
				{dc, io, hm} = {32'd1, 32'd1, 32'd0};
			end
			7'h56:
			begin
				c = LST_LOAD_STRING_OP;
				{ck, dc, hm} = {32'd5, 32'd1, 32'd0};
			end
			7'h52:
			begin
				c = LST_MOVE_STRING_OP;
				{ck, dc, wr, hm} = {32'd7, 32'd2, 32'd2, 32'd0};
			end
			7'h37:
			begin
				c = LST_PORT_OUTPUT_STRING_OP;
				ck = slow ? 28 : 8;
				{dc, wr, io, hm} = {32'd1, 32'd1, 32'd1, 32'd0};
			end
			7'h57:
			begin
				c = LST_SCAN_STRING_OP;
				{ck, dc, hm} = {32'd7, 32'd1, 32'd0};
			end
			7'h55:
			begin
				c = LST_STORE_STRING_OP;
				{ck, dc, wr, hm} = {32'd4, 32'd1, 32'd1, 32'd0};
			end
			7'h6B:
			begin
				c = o[0] ? LST_TABLE_TRANSLATE_OP : LST_NONE;
				{ck, dc, il, hm} = {32'd5, 32'd1, 32'(!o[0]), 32'd0};
			end
			default: {il, hm} = {32'd1, 32'd0};
		endcase
	endfunction : model
	task automatic run(input logic [7:0] o, m, input bit rep, input int n);
		lst_op_e c;
		int ck, dc, wr, io, fl, il, hm, t0, w0, el, k;
		model(o, m, slow_io, c, ck, dc, wr, io, fl, il, hm);
		if (rep)
			{ck, dc} = {5 + 9 * n, 2 * n};
		lst_bus_model_inst.log_q.delete();
		w0 = lst_bus_model_inst.waits;
		if (rep)
			send(8'hF3);
		send(o);
		#1 t0 = cyc;
		if (hm)
			send(m);
		@(negedge clk);
		byte_valid = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 500)
		begin
			@(negedge clk);
			k++;
		end
		el = cyc - t0;
		chk("done", 1, done);
		chk("busy at done", 1, busy);
		chk("illegal", il, illegal);
		if (!il)
		begin
			chk("class", c, op_out);
			chk("flags only", fl, flags_only);
			chk("data cycles", dc, lst_bus_model_inst.log_q.size());
			for (int i = 0; i < dc && i < lst_bus_model_inst.log_q.size(); i++)
			begin
				chk("bus write", (wr >> (i % 2)) & 1, lst_bus_model_inst.log_q[i][2]);
				chk("bus io", io, lst_bus_model_inst.log_q[i][1]);
				if (o != 8'hD7)
					chk("width", o[0], lst_bus_model_inst.log_q[i][0]);
			end
			if (c == LST_LOAD_STRING_OP || c == LST_STORE_STRING_OP)
				chk("acc write", c == LST_LOAD_STRING_OP, writes_accumulator);
			w0 = lst_bus_model_inst.waits - w0;
			// upper bound allows bus waits and a small fetch overhead
			chk("clocks", 1, el >= ck && el <= ck + 2 * dc + 4 + w0);
		end
	endtask : run
	initial
	begin
		logic [7:0] o, m;
		{rst, byte_valid, byte_data, addr32, slow_io} = {1'b1, 1'b0, 8'h00, 1'b0, 1'b0};
		{count_in, compare_equal, err_total, n_compared, cyc} = {32'h0, 1'b1, 96'd0};
		void'($urandom(32'h106e50e8));
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chk("ready after reset", 1, byte_ready);
		chk("busy after reset", 0, busy);
		chk("bus after reset", 0, bus_req);
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 35; i++)
			begin
				{o, m} = tbl[i];
				if (o != 8'hD7)
					o[0] = 1'($urandom % 2);
				m[2:0] = m[7:6] == 2'b11 ? 3'($urandom % 8) : 3'($urandom % 4);
				{slow_io, addr32, count_in} = {1'(p), 1'($urandom % 2), $urandom};
				run(o, m, 1'b0, 0);
			end
		{addr32, count_in} = {1'b0, 32'h0001_0002};
		run(8'hA7, 8'h00, 1'b1, 2);
		{addr32, count_in} = {1'b1, 32'h0000_0003};
		run(8'hA6, 8'h00, 1'b1, 3);
		{compare_equal, count_in} = {1'b0, 32'h0000_0005};
		run(8'hA7, 8'h00, 1'b1, 1);
		end_of_test();
	end
endmodule : logic_string_instr_timing_test
`default_nettype wire
